// ===== diff_start_pkg.sv
// Purpose: shared constants and types for the differential start decision
// Assumes: magnitudes arrive as integers in percent of the reference current
// Notes: settings are clamped into range when software writes them
package diff_start_pkg;
	localparam int MAG_W = 16;
	localparam int SET_W = 16;
	localparam int ADDR_W = 8;
	localparam int CALC_W = 40;
	localparam int PCT_SCALE = 100;

	typedef logic [MAG_W-1:0] mag_t;
	typedef logic [SET_W-1:0] set_t;

	typedef struct packed {
		mag_t diff;
		mag_t prim;
		mag_t sec;
		mag_t ter;
	} phase_mag_t;

	typedef struct packed {
		logic [2:0] restrainedPhase;
		logic [2:0] unrestrainedPhase;
		logic restrainedGeneral;
		logic unrestrainedGeneral;
	} start_flags_t;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_HIGH_LIMIT = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_BASE_SENS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_SLOPE1 = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_BIAS_LIMIT = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_SLOPE2 = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h1C;

	// Setting ranges and defaults
	localparam set_t HIGH_LIMIT_MIN = 16'h0320;
	localparam set_t HIGH_LIMIT_MAX = 16'h09C4;
	localparam set_t HIGH_LIMIT_RST = 16'h0320;
	localparam set_t BASE_SENS_MIN = 16'h000A;
	localparam set_t BASE_SENS_MAX = 16'h0032;
	localparam set_t BASE_SENS_RST = 16'h0014;
	localparam set_t SLOPE1_MIN = 16'h000A;
	localparam set_t SLOPE1_MAX = 16'h0032;
	localparam set_t SLOPE1_RST = 16'h0014;
	localparam set_t BIAS_LIMIT_MIN = 16'h00C8;
	localparam set_t BIAS_LIMIT_MAX = 16'h07D0;
	localparam set_t BIAS_LIMIT_RST = 16'h00C8;
	localparam set_t SLOPE2_MIN = 16'h001E;
	localparam set_t SLOPE2_MAX = 16'h00C8;
	localparam set_t SLOPE2_RST = 16'h00C8;

	// Interrupt status / mask layout
	localparam int IRQ_RESTRAINED_BIT = 0;
	localparam int IRQ_UNRESTRAINED_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
endpackage

// ===== differential_start_decision.sv
// Purpose: per-phase restrained and unrestrained start decision
// Assumes: magnitudes come from logic on the same clock, valid for one cycle
// Notes: start outputs hold between valid samples unless blocked; settings live in registers
//
// Chosen here: the register addresses and the address-and-strobe port.
module differential_start_decision
	import diff_start_pkg::*;
#(
	parameter bit THREE_WINDING = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic magValid,
	input wire phase_mag_t [2:0] phaseMag,
	input wire logic [2:0] secondHarmRestraint,
	input wire logic [2:0] fifthHarmRestraint,
	input wire logic userBlockInput,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output start_flags_t starts,
	output logic irq
);
	function automatic set_t clampSet(input logic [31:0] v, input set_t lo, input set_t hi);
		if (v < 32'(lo)) begin
			return lo;
		end else if (v > 32'(hi)) begin
			return hi;
		end
		return v[SET_W-1:0];
	endfunction

	set_t highLimit_q, baseSens_q, slope1_q, biasLimit_q, slope2_q;
	set_t highLimit_d, baseSens_d, slope1_d, biasLimit_d, slope2_d;
	logic [IRQ_W-1:0] irqStatus_q, irqStatus_d, irqMask_q, irqMask_d, irqEvent;
	start_flags_t starts_q, starts_d;
	logic [31:0] rdData_q, rdData_d;
	logic [2:0] aboveChar, aboveHigh;

	// Settings writes, clamped so the characteristic is never out of range
	always_comb begin
		highLimit_d = highLimit_q;
		baseSens_d = baseSens_q;
		slope1_d = slope1_q;
		biasLimit_d = biasLimit_q;
		slope2_d = slope2_q;
		irqMask_d = irqMask_q;
		if (regWr) begin
			if (regAddr == ADDR_HIGH_LIMIT) begin
				highLimit_d = clampSet(regWrData, HIGH_LIMIT_MIN, HIGH_LIMIT_MAX);
			end else if (regAddr == ADDR_BASE_SENS) begin
				baseSens_d = clampSet(regWrData, BASE_SENS_MIN, BASE_SENS_MAX);
			end else if (regAddr == ADDR_SLOPE1) begin
				slope1_d = clampSet(regWrData, SLOPE1_MIN, SLOPE1_MAX);
			end else if (regAddr == ADDR_BIAS_LIMIT) begin
				biasLimit_d = clampSet(regWrData, BIAS_LIMIT_MIN, BIAS_LIMIT_MAX);
			end else if (regAddr == ADDR_SLOPE2) begin
				slope2_d = clampSet(regWrData, SLOPE2_MIN, SLOPE2_MAX);
			end else if (regAddr == ADDR_IRQ_MASK) begin
				irqMask_d = regWrData[IRQ_W-1:0];
			end
		end
	end

	// One short register per setting, reset value beside its flop
	always_ff @(posedge clk) begin
		if (srst) begin
			highLimit_q <= HIGH_LIMIT_RST;
		end else begin
			highLimit_q <= highLimit_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			baseSens_q <= BASE_SENS_RST;
		end else begin
			baseSens_q <= baseSens_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slope1_q <= SLOPE1_RST;
		end else begin
			slope1_q <= slope1_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			biasLimit_q <= BIAS_LIMIT_RST;
		end else begin
			biasLimit_q <= biasLimit_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slope2_q <= SLOPE2_RST;
		end else begin
			slope2_q <= slope2_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irqMask_q <= IRQ_MASK_RST;
		end else begin
			irqMask_q <= irqMask_d;
		end
	end

	// Per-phase characteristic evaluation, scaled by 100 to avoid division
	for (genvar ph = 0; ph < 3; ph++) begin : g_phase
		wire logic [MAG_W+1:0] terMag = THREE_WINDING ? {2'b00, phaseMag[ph].ter} : '0;
		wire logic [MAG_W+1:0] windSum = {2'b00, phaseMag[ph].prim} + {2'b00, phaseMag[ph].sec} + terMag;
		wire logic [MAG_W+1:0] bias = windSum >> 1;
		wire logic [CALC_W-1:0] diffScaled = CALC_W'(phaseMag[ph].diff) * CALC_W'(PCT_SCALE);
		wire logic [CALC_W-1:0] floorThr = CALC_W'(baseSens_q) * CALC_W'(PCT_SCALE);
		wire logic upperSection = CALC_W'(bias) > CALC_W'(biasLimit_q);
		wire logic [CALC_W-1:0] slope1Thr = CALC_W'(slope1_q) * CALC_W'(bias);
		wire logic [CALC_W-1:0] kneeThr = CALC_W'(slope1_q) * CALC_W'(biasLimit_q);
		wire logic [CALC_W-1:0] slope2Thr = kneeThr + CALC_W'(slope2_q) * (CALC_W'(bias) - CALC_W'(biasLimit_q));
		wire logic [CALC_W-1:0] slopeThr = upperSection ? slope2Thr : slope1Thr;
		wire logic [CALC_W-1:0] charThr = (slopeThr > floorThr) ? slopeThr : floorThr;
		assign aboveChar[ph] = diffScaled > charThr;
		assign aboveHigh[ph] = CALC_W'(phaseMag[ph].diff) > CALC_W'(highLimit_q);
	end

	// Harmonic restraint holds back only the restrained general start;
	// unrestrained ignores harmonics by design since inrush never reaches it
	wire logic [2:0] restrainedFree = aboveChar & ~secondHarmRestraint & ~fifthHarmRestraint;
	wire logic notBlocked = ~userBlockInput;

	always_comb begin
		starts_d = starts_q;
		// Block also drops starts held from an earlier sample
		if (userBlockInput) begin
			starts_d = '0;
		end else if (magValid) begin
			starts_d.restrainedPhase = aboveChar & {3{notBlocked}};
			starts_d.unrestrainedPhase = aboveHigh & {3{notBlocked}};
			starts_d.restrainedGeneral = (|restrainedFree) & notBlocked;
			starts_d.unrestrainedGeneral = (|aboveHigh) & notBlocked;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			starts_q <= '0;
		end else begin
			starts_q <= starts_d;
		end
	end

	assign starts = starts_q;

	// Rising general starts are the interrupt events
	assign irqEvent[IRQ_RESTRAINED_BIT] = starts_d.restrainedGeneral & ~starts_q.restrainedGeneral;
	assign irqEvent[IRQ_UNRESTRAINED_BIT] = starts_d.unrestrainedGeneral & ~starts_q.unrestrainedGeneral;

	wire logic irqClearHit = regWr && (regAddr == ADDR_IRQ_STATUS);
	wire logic [IRQ_W-1:0] irqClear = irqClearHit ? regWrData[IRQ_W-1:0] : '0;

	// Set wins over a simultaneous write-one-to-clear
	assign irqStatus_d = (irqStatus_q & ~irqClear) | irqEvent;

	always_ff @(posedge clk) begin
		if (srst) begin
			irqStatus_q <= '0;
		end else begin
			irqStatus_q <= irqStatus_d;
		end
	end

	assign irq = |(irqStatus_q & irqMask_q);

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdData_d = 32'h0000_0000;
		if (regAddr == ADDR_HIGH_LIMIT) begin
			rdData_d = 32'(highLimit_q);
		end else if (regAddr == ADDR_BASE_SENS) begin
			rdData_d = 32'(baseSens_q);
		end else if (regAddr == ADDR_SLOPE1) begin
			rdData_d = 32'(slope1_q);
		end else if (regAddr == ADDR_BIAS_LIMIT) begin
			rdData_d = 32'(biasLimit_q);
		end else if (regAddr == ADDR_SLOPE2) begin
			rdData_d = 32'(slope2_q);
		end else if (regAddr == ADDR_FLAGS) begin
			rdData_d = 32'(starts_q);
		end else if (regAddr == ADDR_IRQ_STATUS) begin
			rdData_d = 32'(irqStatus_q);
		end else if (regAddr == ADDR_IRQ_MASK) begin
			rdData_d = 32'(irqMask_q);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_q <= 32'h0000_0000;
		end else if (regRd) begin
			rdData_q <= rdData_d;
		end else begin
			rdData_q <= 32'h0000_0000;
		end
	end

	assign regRdData = rdData_q;
endmodule

// ===== mag_source.sv
// Purpose: upstream magnitude and harmonic flag model
// Assumes: one sample per go pulse
// Notes: idle bus shows inverted data, so a stale sample cannot pass
module mag_source
	import diff_start_pkg::*;
(
	input wire logic clk,
	input wire logic go,
	input wire phase_mag_t [2:0] magIn,
	input wire logic [2:0] h2In,
	input wire logic [2:0] h5In,
	output logic magValid,
	output phase_mag_t [2:0] phaseMag,
	output logic [2:0] secondHarmRestraint,
	output logic [2:0] fifthHarmRestraint
);
	timeunit 1ns;
	timeprecision 1ns;
	initial magValid = 1'b0;
	initial phaseMag = '0;
	always @(posedge clk) begin
		magValid <= go;
		phaseMag <= go ? magIn : ~phaseMag;
		secondHarmRestraint <= h2In;
		fifthHarmRestraint <= h5In;
	end
endmodule

// ===== dsd_checker.sv
// Purpose: port checker for the start decision
// Assumes: settings stay inside their ranges
// Notes: thresholds bounded by range limits, registers are unseen
module dsd_checker
	import diff_start_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic magValid,
	input wire phase_mag_t [2:0] phaseMag,
	input wire logic userBlockInput,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire start_flags_t starts
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_unrGen; starts.unrestrainedGeneral == |starts.unrestrainedPhase; endproperty
	a_unrGen: assert property (p_unrGen) else $error("unrestrained general not OR");
	property p_resGen; starts.restrainedGeneral |-> |starts.restrainedPhase; endproperty
	a_resGen: assert property (p_resGen) else $error("restrained general without phase");
	property p_block; magValid && userBlockInput |=> starts == '0; endproperty
	a_block: assert property (p_block) else $error("start while blocked");
	property p_blockAny; userBlockInput |=> starts == '0; endproperty
	a_blockAny: assert property (p_blockAny) else $error("start held while blocked");
	property p_hold; !magValid && !userBlockInput |=> $stable(starts); endproperty
	a_hold: assert property (p_hold) else $error("starts moved without sample");
	property p_rdIdle; !regRd |=> regRdData == 32'h0000_0000; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	for (genvar i = 0; i < 3; i++) begin : g_ph
		property p_unrHi; magValid && !userBlockInput && phaseMag[i].diff > HIGH_LIMIT_MAX |=> starts.unrestrainedPhase[i]; endproperty
		a_unrHi: assert property (p_unrHi) else $error("unrestrained start missing");
		property p_unrLo; magValid && phaseMag[i].diff <= HIGH_LIMIT_MIN |=> !starts.unrestrainedPhase[i]; endproperty
		a_unrLo: assert property (p_unrLo) else $error("unrestrained start below limit");
		property p_floor; magValid && phaseMag[i].diff <= BASE_SENS_MIN |=> !starts.restrainedPhase[i]; endproperty
		a_floor: assert property (p_floor) else $error("restrained start below floor");
	end
endmodule

// ===== differential_start_decision_tb.sv
// Purpose: self-checking bench for the start decision
// Assumes: default settings unless a scenario writes them
// Notes: expected flags worked by hand from the characteristic
module differential_start_decision_tb
	import diff_start_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, go = 0, userBlockInput = 0, regWr = 0, regRd = 0, magValid, irq;
	phase_mag_t [2:0] magIn = '0, phaseMag;
	logic [2:0] h2In = 0, h5In = 0, secondHarmRestraint, fifthHarmRestraint;
	logic [ADDR_W-1:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData;
	start_flags_t starts;
	int nMismatch = 0, checkCount = 0;
	mag_source u_src(.clk(clk), .go(go), .magIn(magIn), .h2In(h2In), .h5In(h5In), .magValid(magValid),
		.phaseMag(phaseMag), .secondHarmRestraint(secondHarmRestraint), .fifthHarmRestraint(fifthHarmRestraint));
	differential_start_decision u_dut(.clk(clk), .srst(srst), .magValid(magValid), .phaseMag(phaseMag),
		.secondHarmRestraint(secondHarmRestraint), .fifthHarmRestraint(fifthHarmRestraint),
		.userBlockInput(userBlockInput), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .starts(starts), .irq(irq));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 0;
		#1;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 0;
		#1 chk(nm, regRdData, e);
	endtask
	task automatic smp(input mag_t d0, d1, d2, w0, w1, input logic [2:0] h2, h5, input logic blk, input logic [7:0] e);
		@(posedge clk);
		go <= 1;
		magIn <= '{'{d2, 16'h0000, 16'h0000, 16'h0000}, '{d1, w1, w1, w1}, '{d0, w0, w0, w0}};
		h2In <= h2;
		h5In <= h5;
		userBlockInput <= blk;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		#1 chk("starts", 32'(starts), 32'(e));
	endtask
	task automatic t_settings;
		rdc("highLimit", ADDR_HIGH_LIMIT, 32'h0000_0320);
		rdc("baseSens", ADDR_BASE_SENS, 32'h0000_0014);
		rdc("slope1", ADDR_SLOPE1, 32'h0000_0014);
		rdc("biasLimit", ADDR_BIAS_LIMIT, 32'h0000_00C8);
		rdc("slope2", ADDR_SLOPE2, 32'h0000_00C8);
		rdc("unmapped", 8'h20, 32'h0000_0000);
		wr(ADDR_HIGH_LIMIT, 32'h0000_0BB8);
		rdc("limitTop", ADDR_HIGH_LIMIT, 32'h0000_09C4);
		wr(ADDR_HIGH_LIMIT, 32'h0000_0064);
		rdc("limitBottom", ADDR_HIGH_LIMIT, 32'h0000_0320);
	endtask
	task automatic t_unrestrained;
		smp(800, 801, 2600, 0, 0, 0, 0, 0, 8'hFB);
		rdc("flags", ADDR_FLAGS, 32'h0000_00FB);
		chk("irqMasked", 32'(irq), 32'h0000_0000);
		rdc("irqStatus", ADDR_IRQ_STATUS, 32'h0000_0003);
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		chk("irqOn", 32'(irq), 32'h0000_0001);
		wr(ADDR_IRQ_STATUS, 32'h0000_0003);
		chk("irqCleared", 32'(irq), 32'h0000_0000);
		smp(801, 801, 2600, 0, 0, 0, 0, 1, 8'h00);
	endtask
	task automatic t_restrained;
		// Bias 501 on phase 0 (third winding included) sits on the second slope, phase 2 starts on the base floor
		smp(642, 25, 21, 334, 100, 0, 0, 0, 8'h82);
		smp(643, 25, 21, 334, 100, 0, 0, 0, 8'hA2);
		smp(643, 25, 21, 334, 100, 3'b101, 0, 0, 8'hA0);
		smp(643, 25, 21, 334, 100, 0, 3'b101, 0, 8'hA0);
	endtask
	task automatic t_block_reset;
		wr(ADDR_HIGH_LIMIT, 32'h0000_09C4);
		smp(2500, 2501, 10, 0, 0, 0, 0, 0, 8'h6B);
		chk("irqBoth", 32'(irq), 32'h0000_0001);
		@(posedge clk);
		userBlockInput <= 1;
		@(posedge clk);
		#1 chk("blockHold", 32'(starts), 32'h0000_0000);
		@(posedge clk);
		userBlockInput <= 0;
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		#1 chk("rstStarts", 32'(starts), 32'h0000_0000);
		chk("rstIrq", 32'(irq), 32'h0000_0000);
		rdc("rstLimit", ADDR_HIGH_LIMIT, 32'h0000_0320);
		rdc("rstMask", ADDR_IRQ_MASK, 32'h0000_0000);
	endtask
	task automatic close_out;
		if (nMismatch == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		srst <= 0;
		t_settings();
		t_unrestrained();
		t_restrained();
		t_block_reset();
		close_out();
	end
	initial begin
		#100000;
		nMismatch++;
		close_out();
	end
endmodule
bind differential_start_decision dsd_checker u_chk(.clk(clk), .srst(srst), .magValid(magValid), .phaseMag(phaseMag),
	.userBlockInput(userBlockInput), .regRd(regRd), .regRdData(regRdData), .starts(starts));
